// ===== hw/nip_consts.svh
`ifndef NIP_CONSTS_SVH
`define NIP_CONSTS_SVH

`define NIP_NSRC 8
`define NIP_NLEVEL 8
// request to acknowledge, in internal system clocks
`define NIP_LAT_MIN_CYC 4
`define NIP_LAT_MAX_CYC 8
// age at which a pending request may win; the grant flop adds one and the
// capture of the request adds one more
`define NIP_ACK_AGE (`NIP_LAT_MIN_CYC - 2)
`define NIP_AGE_MAX 3'h7
`define NIP_STATUS_SYSREG 5'h05

`define NIP_OFS_SRC_CTRL0 8'h00
`define NIP_OFS_EXT_MODE 8'h20
`define NIP_OFS_STATUS 8'h24
`define NIP_OFS_LAST_SRC 8'h1c

`define NIP_CTRL_PRIO_LSB 0
`define NIP_CTRL_PRIO_MSB 2
`define NIP_CTRL_MASK_BIT 6
`define NIP_STAT_INSVC_LSB 8
`define NIP_STAT_NMI_BIT 16

`define NIP_RST_PRIO 3'h7
`define NIP_RST_MASK 1'b1
`define NIP_RST_EXT_MODE 8'h00

`define NIP_RESP_OKAY 2'h0
`define NIP_RESP_SLVERR 2'h2

`endif

// ===== hw/nip_pkg.sv
package nip_pkg;

    typedef enum logic [2:0]
    {
        INSTR_OTHER,
        INSTR_ENABLE_INT,
        INSTR_DISABLE_INT,
        INSTR_SYSREG_LOAD,
        INSTR_STORE_PROTECT,
        INSTR_STORE_CTRL,
        INSTR_BITOP_CTRL,
        INSTR_BIT_TEST
    } instr_kind_t;

    // one retired instruction from the pipeline
    typedef struct packed
    {
        logic valid;
        instr_kind_t kind;
        logic [4:0] sysreg;
    } retire_t;

    typedef struct packed
    {
        logic nmi_entry;
        logic return_from_interrupt_instr;
        logic int_disable;
        logic hold_off;
    } cpu_status_t;

    typedef struct packed
    {
        logic valid;
        logic [2:0] src;
        logic [2:0] level;
    } grant_t;

endpackage

// ===== hw/nip_arbiter.sv
`timescale 1ns/1ps
`include "nip_consts.svh"

module nip_arbiter
(
    input wire logic [`NIP_NSRC-1:0] eligible,
    input wire logic [`NIP_NSRC-1:0][2:0] prio,
    output logic found,
    output logic [2:0] idx,
    output logic [2:0] level
);

    always_comb
    begin
        found = 1'b0;
        idx = 3'h0;
        level = 3'h7;
        // strict compare keeps the lowest index among equal levels
        for (int i = 0; i < `NIP_NSRC; i++)
        begin
            if (eligible[i] && (!found || prio[i] < level))
            begin
                found = 1'b1;
                idx = 3'(i);
                level = prio[i];
            end
        end
    end

endmodule

// ===== hw/nested_interrupt_priority_ctrl.sv
`timescale 1ns/1ps
`include "nip_consts.svh"

// Contract
// - higher priority request pre-empts running handler
// - lower priority request stays pending, not acknowledged
// - no maskable acceptance while disable flag set
// - three-bit priority per source, 0 highest
// - reset: all sources masked, level seven
// - pre-empted handler resumes after higher return
// - pending request waits for handler return
// - maskable requests held off during nmi servicing
// - internal acknowledge no sooner than four clocks
// - worst case eight clocks, pins add delay
// - filtered pin adds its filter delay
// - latency bounds void in idle, stop, access
// - no acknowledge right after a blocking instruction
// - blocking set: ei, di, status load, control stores
// - external pin mode suppresses shared peripheral requests

module nested_interrupt_priority_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [`NIP_NSRC-1:0] periph_req,
    input wire logic [`NIP_NSRC-1:0] external_int_pin,
    input wire nip_pkg::cpu_status_t cpu_status,
    input wire nip_pkg::retire_t retire,
    output nip_pkg::grant_t grant
);

    ////////////////////////////////////////////////////////////////////////
    // register bus

    logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_lane_reg, w_lane_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [`NIP_NSRC-1:0][2:0] prio_reg, prio_next;
    logic [`NIP_NSRC-1:0] mask_reg, mask_next;
    logic [`NIP_NSRC-1:0] ext_mode_reg, ext_mode_next;
    logic [`NIP_NSRC-1:0] pending_vec;
    logic [`NIP_NSRC-1:0] in_service_reg, in_service_next;
    logic nmi_active_reg, nmi_active_next;
    logic do_write;

    assign awready = !aw_full_reg && !bvalid_reg;
    assign wready = !w_full_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rresp = rresp_reg;
    assign rdata = rdata_reg;
    assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;

    always_comb
    begin
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next = w_full_reg;
        w_data_next = w_data_reg;
        w_lane_next = w_lane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        prio_next = prio_reg;
        mask_next = mask_reg;
        ext_mode_next = ext_mode_reg;
        if (awvalid && awready)
        begin
            aw_full_next = 1'b1;
            aw_addr_next = awaddr;
        end
        if (wvalid && wready)
        begin
            w_full_next = 1'b1;
            w_data_next = wdata[7:0];
            w_lane_next = wstrb[0];
        end
        if (do_write)
        begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `NIP_RESP_OKAY;
            // only the low byte lane carries settings
            if (aw_addr_reg[1:0] != 2'h0)
                bresp_next = `NIP_RESP_SLVERR;
            else if (aw_addr_reg <= `NIP_OFS_LAST_SRC)
            begin
                if (w_lane_reg)
                begin
                    prio_next[aw_addr_reg[4:2]] =
                        w_data_reg[`NIP_CTRL_PRIO_MSB:`NIP_CTRL_PRIO_LSB];
                    mask_next[aw_addr_reg[4:2]] = w_data_reg[`NIP_CTRL_MASK_BIT];
                end
            end
            else if (aw_addr_reg == `NIP_OFS_EXT_MODE)
            begin
                if (w_lane_reg)
                    ext_mode_next = w_data_reg;
            end
            else if (aw_addr_reg != `NIP_OFS_STATUS)
                bresp_next = `NIP_RESP_SLVERR;
        end
        if (bvalid_reg && bready)
            bvalid_next = 1'b0;
        if (arvalid && arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = `NIP_RESP_OKAY;
            rdata_next = 32'h0000_0000;
            if (araddr[1:0] != 2'h0)
                rresp_next = `NIP_RESP_SLVERR;
            else if (araddr <= `NIP_OFS_LAST_SRC)
            begin
                rdata_next[`NIP_CTRL_PRIO_MSB:`NIP_CTRL_PRIO_LSB] = prio_reg[araddr[4:2]];
                rdata_next[`NIP_CTRL_MASK_BIT] = mask_reg[araddr[4:2]];
            end
            else if (araddr == `NIP_OFS_EXT_MODE)
                rdata_next[`NIP_NSRC-1:0] = ext_mode_reg;
            else if (araddr == `NIP_OFS_STATUS)
            begin
                rdata_next[`NIP_NSRC-1:0] = pending_vec;
                rdata_next[`NIP_STAT_INSVC_LSB +: `NIP_NSRC] = in_service_reg;
                rdata_next[`NIP_STAT_NMI_BIT] = nmi_active_reg;
            end
            else
                rresp_next = `NIP_RESP_SLVERR;
        end
        else if (rvalid_reg && rready)
            rvalid_next = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `NIP_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= `NIP_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
            prio_reg <= {`NIP_NSRC{`NIP_RST_PRIO}};
            mask_reg <= {`NIP_NSRC{`NIP_RST_MASK}};
            ext_mode_reg <= `NIP_RST_EXT_MODE;
        end
        else
        begin
            aw_full_reg <= aw_full_next;
            aw_addr_reg <= aw_addr_next;
            w_full_reg <= w_full_next;
            w_data_reg <= w_data_next;
            w_lane_reg <= w_lane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            prio_reg <= prio_next;
            mask_reg <= mask_next;
            ext_mode_reg <= ext_mode_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // request capture and age

    logic [`NIP_NSRC-1:0][2:0] age_vec;
    logic [`NIP_NSRC-1:0] eligible;
    logic [`NIP_NSRC-1:0] accept_src;
    logic accept;
    logic win_found;
    logic [2:0] win_idx, win_level;

    genvar g;
    generate
        for (g = 0; g < `NIP_NSRC; g++)
        begin : gen_src
            logic raw_req;
            logic pend_reg, pend_next;
            logic [2:0] age_reg, age_next;

            // in pin mode the shared peripheral request is dropped; a filtered
            // pin arrives here already delayed by its filter
            assign raw_req = ext_mode_reg[g] ? external_int_pin[g] : periph_req[g];

            always_comb
            begin
                pend_next = pend_reg;
                age_next = age_reg;
                if (pend_reg && age_reg != `NIP_AGE_MAX)
                    age_next = age_reg + 3'h1;
                if (accept_src[g])
                    pend_next = 1'b0;
                // a new request beats the clearing acknowledge
                if (raw_req)
                begin
                    pend_next = 1'b1;
                    age_next = 3'h0;
                end
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    pend_reg <= 1'b0;
                    age_reg <= 3'h0;
                end
                else
                begin
                    pend_reg <= pend_next;
                    age_reg <= age_next;
                end
            end

            assign pending_vec[g] = pend_reg;
            assign age_vec[g] = age_reg;
            assign eligible[g] = pend_reg && !mask_reg[g] &&
                age_reg >= 3'(`NIP_ACK_AGE);
            assign accept_src[g] = accept && win_idx == 3'(g);

            // a fresh request must not be granted in its first three cycles
            a_ack_min_age: assert property (@(posedge aclk) disable iff (!aresetn)
                raw_req && !pend_reg |=> (!(grant.valid && grant.src == 3'(g))) [*3])
                else $error("grant before minimum latency");
        end
    endgenerate

    nip_arbiter nip_arbiter_inst
    (
        .eligible(eligible),
        .prio(prio_reg),
        .found(win_found),
        .idx(win_idx),
        .level(win_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // nesting state and acceptance

    logic block_reg, block_next;
    logic retire_blocks;
    logic any_in_service;
    logic [2:0] cur_level;
    nip_pkg::grant_t grant_reg, grant_next;

    always_comb
    begin
        any_in_service = 1'b0;
        cur_level = 3'h7;
        for (int l = `NIP_NLEVEL - 1; l >= 0; l--)
        begin
            if (in_service_reg[l])
            begin
                any_in_service = 1'b1;
                cur_level = 3'(l);
            end
        end
    end

    always_comb
    begin
        case (retire.kind)
            nip_pkg::INSTR_ENABLE_INT,
            nip_pkg::INSTR_DISABLE_INT,
            nip_pkg::INSTR_STORE_PROTECT,
            nip_pkg::INSTR_STORE_CTRL,
            nip_pkg::INSTR_BITOP_CTRL: retire_blocks = 1'b1;
            nip_pkg::INSTR_SYSREG_LOAD:
                retire_blocks = retire.sysreg == `NIP_STATUS_SYSREG;
            default: retire_blocks = 1'b0;
        endcase
    end

    // the return cycle itself never grants, so the pop and a push never meet
    assign accept = win_found && !cpu_status.int_disable &&
        !nmi_active_reg && !cpu_status.nmi_entry &&
        !block_reg &&
        !cpu_status.hold_off &&
        !cpu_status.return_from_interrupt_instr &&
        (!any_in_service || win_level < cur_level);

    always_comb
    begin
        in_service_next = in_service_reg;
        nmi_active_next = nmi_active_reg;
        block_next = block_reg;
        grant_next = '0;
        if (retire.valid)
            block_next = retire_blocks;
        if (cpu_status.nmi_entry)
            nmi_active_next = 1'b1;
        else if (cpu_status.return_from_interrupt_instr && nmi_active_reg)
            nmi_active_next = 1'b0;
        else if (cpu_status.return_from_interrupt_instr && any_in_service)
            in_service_next[cur_level] = 1'b0;
        if (accept)
        begin
            in_service_next[win_level] = 1'b1;
            grant_next.valid = 1'b1;
            grant_next.src = win_idx;
            grant_next.level = win_level;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_service_reg <= '0;
            nmi_active_reg <= 1'b0;
            block_reg <= 1'b0;
            grant_reg <= '0;
        end
        else
        begin
            in_service_reg <= in_service_next;
            nmi_active_reg <= nmi_active_next;
            block_reg <= block_next;
            grant_reg <= grant_next;
        end
    end

    assign grant = grant_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_disable_blocks: assert property ($past(cpu_status.int_disable) |->
        !grant.valid)
        else $error("grant while interrupts disabled");
    a_nmi_holdoff: assert property (nmi_active_reg |=> !grant.valid)
        else $error("grant during nmi servicing");
    a_gap_block: assert property (block_reg |=> !grant.valid)
        else $error("grant after blocking instruction");
    a_preempt_higher: assert property (grant.valid && $past(any_in_service) |->
        grant.level < $past(cur_level))
        else $error("grant not above current level");
    a_mask_honoured: assert property (grant.valid |->
        ($past(mask_reg) & (8'h01 << grant.src)) == 8'h00)
        else $error("masked source granted");
    a_reset_values: assert property ($rose(aresetn) |->
        mask_reg == {`NIP_NSRC{1'b1}} && prio_reg == {`NIP_NSRC{`NIP_RST_PRIO}})
        else $error("bad reset priority or mask");
    a_return_from_interrupt_instr_pops: assert property (cpu_status.return_from_interrupt_instr && !nmi_active_reg &&
        any_in_service && !cpu_status.nmi_entry |=>
        $countones(in_service_reg) == $countones($past(in_service_reg)) - 1)
        else $error("return did not pop one level");
    a_grant_pulse: assert property (grant.valid |=> !grant.valid ||
        grant.level < $past(grant.level))
        else $error("second grant not a pre-emption");
    a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    c_nested: cover property (grant.valid && $past(any_in_service));
    c_nmi_wait: cover property (nmi_active_reg && |eligible);
    c_tie: cover property (grant.valid && $countones(eligible & ~accept_src) > 0);
    c_blocked: cover property (block_reg && win_found);

endmodule

// ===== testbench/cpu_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module cpu_model
(
    input wire logic aclk,
    output logic [7:0] periph_req,
    output logic [7:0] external_int_pin,
    output nip_pkg::cpu_status_t cpu_status,
    output nip_pkg::retire_t retire
);
    int cyc = 0;
    int last[8];

    initial
    begin
        periph_req = 8'h00;
        external_int_pin = 8'h00;
        cpu_status = '0;
        retire = '0;
        foreach (last[i])
            last[i] = -10;
    end

    always @(posedge aclk)
        cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle request on the sources in m; a source waits out its spacing
    task automatic fire(input logic [7:0] m, input logic pin);
        int i;
        for (i = 0; i < 8; i++)
            while (m[i] && cyc - last[i] < 4) @(posedge aclk);
        for (i = 0; i < 8; i++)
            if (m[i])
                last[i] = cyc;
        if (pin)
            external_int_pin <= m;
        else
            periph_req <= m;
        @(posedge aclk);
        periph_req <= 8'h00;
        external_int_pin <= 8'h00;
    endtask

    task automatic pulse_status(input logic nmi, input logic ret);
        cpu_status.nmi_entry <= nmi;
        cpu_status.return_from_interrupt_instr <= ret;
        @(posedge aclk);
        cpu_status.nmi_entry <= 1'b0;
        cpu_status.return_from_interrupt_instr <= 1'b0;
    endtask

    task automatic levels(input logic dis, input logic hold);
        cpu_status.int_disable <= dis;
        cpu_status.hold_off <= hold;
        @(posedge aclk);
    endtask

    task automatic retire_one(input nip_pkg::instr_kind_t k, input logic [4:0] r);
        retire <= '{1'b1, k, r};
        @(posedge aclk);
        retire <= '0;
    endtask
endmodule

// ===== testbench/test_nested_interrupt_priority_ctrl.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module test_nested_interrupt_priority_ctrl;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd;
    logic [7:0] periph_req, external_int_pin;
    nip_pkg::cpu_status_t cpu_status;
    nip_pkg::retire_t retire;
    nip_pkg::grant_t grant;
    int n_errors = 0;
    int checks = 0;
    int i;
    nip_pkg::instr_kind_t kinds[8] = '{nip_pkg::INSTR_ENABLE_INT, nip_pkg::INSTR_DISABLE_INT,
        nip_pkg::INSTR_SYSREG_LOAD, nip_pkg::INSTR_SYSREG_LOAD, nip_pkg::INSTR_STORE_PROTECT,
        nip_pkg::INSTR_STORE_CTRL, nip_pkg::INSTR_BITOP_CTRL, nip_pkg::INSTR_BIT_TEST};

    always #25 aclk = ~aclk;

    nested_interrupt_priority_ctrl nested_interrupt_priority_ctrl_inst
    (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .periph_req(periph_req), .external_int_pin(external_int_pin),
        .cpu_status(cpu_status), .retire(retire), .grant(grant)
    );

    cpu_model cpu_model_inst
    (
        .aclk(aclk), .periph_req(periph_req), .external_int_pin(external_int_pin),
        .cpu_status(cpu_status), .retire(retire)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic fail(input string m);
        n_errors++;
        $display("wrong value at %0t: %s", $time, m);
        conclude;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (bvalid === 1'b1)
            begin
                r = bresp;
                return;
            end
            if (!ta && awready === 1'b1)
            begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (!tw && wready === 1'b1)
            begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        fail("write hang");
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++)
        begin
            @(posedge aclk);
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                return;
            end
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        fail("read hang");
    endtask

    // n counts cycles since the request cycle; grant is a registered pulse
    task automatic want_grant(input logic [2:0] s, input logic [2:0] l, input int lo);
        int n;
        for (n = 1; n <= 12; n++)
        begin
            @(posedge aclk);
            if (grant.valid === 1'b1)
            begin
                chk(32'({n >= lo && n <= 8, grant.src, grant.level}), 32'({1'b1, s, l}), "grant");
                return;
            end
        end
        fail("no grant");
    endtask

    task automatic want_none(input int c);
        int n;
        for (n = 0; n < c; n++)
        begin
            @(posedge aclk);
            chk(32'(grant.valid), 32'h0, "grant held off");
        end
    endtask

    task automatic return_from_interrupt_instr;
        cpu_model_inst.pulse_status(1'b0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 8; i++)
        begin
            axi_read(8'(4 * i), rd, resp);
            chk(rd, 32'h47, "ctrl after reset");
        end
        // low lane off: the settings byte must stay untouched
        wstrb <= 4'he;
        axi_write(8'h00, 32'h3, resp);
        wstrb <= 4'hf;
        axi_read(8'h00, rd, resp);
        chk(rd, 32'h47, "write without low lane");
        axi_write(8'h06, 32'h0, resp);
        chk(32'(resp), 32'h2, "unaligned write");
        axi_read(8'h02, rd, resp);
        chk({rd[29:0], resp}, 32'h2, "unaligned read");
        axi_write(8'h24, 32'hffffffff, resp);
        axi_read(8'h24, rd, resp);
        chk(rd, 32'h0, "status read only");
        axi_read(8'h40, rd, resp);
        chk({rd[29:0], resp}, 32'h2, "unmapped read");
        axi_write(8'h40, 32'h1, resp);
        chk(32'(resp), 32'h2, "unmapped write");
        for (i = 0; i < 8; i++)
        begin
            axi_write(8'(4 * i), 32'(i), resp);
            axi_read(8'(4 * i), rd, resp);
            chk(rd, 32'(i), "priority field");
        end
        $display("test registers complete");
        cpu_model_inst.fire(8'h08, 1'b0);
        want_grant(3'h3, 3'h3, 4);
        return_from_interrupt_instr;
        $display("test latency complete");
        cpu_model_inst.fire(8'h20, 1'b0);
        want_grant(3'h5, 3'h5, 4);
        cpu_model_inst.fire(8'h04, 1'b0);
        want_grant(3'h2, 3'h2, 4);
        cpu_model_inst.fire(8'h80, 1'b0);
        want_none(12);
        return_from_interrupt_instr;
        want_none(12);
        axi_read(8'h24, rd, resp);
        chk(rd, 32'h2080, "in service and pending");
        return_from_interrupt_instr;
        want_grant(3'h7, 3'h7, 1);
        return_from_interrupt_instr;
        $display("test nesting complete");
        cpu_model_inst.levels(1'b1, 1'b0);
        cpu_model_inst.fire(8'h02, 1'b0);
        want_none(12);
        cpu_model_inst.levels(1'b0, 1'b0);
        want_grant(3'h1, 3'h1, 1);
        return_from_interrupt_instr;
        // let the return pulse drop before the status lines are driven again
        @(posedge aclk);
        cpu_model_inst.pulse_status(1'b1, 1'b0);
        cpu_model_inst.fire(8'h01, 1'b0);
        want_none(12);
        return_from_interrupt_instr;
        want_grant(3'h0, 3'h0, 1);
        return_from_interrupt_instr;
        cpu_model_inst.levels(1'b0, 1'b1);
        cpu_model_inst.fire(8'h08, 1'b0);
        want_none(12);
        cpu_model_inst.levels(1'b0, 1'b0);
        want_grant(3'h3, 3'h3, 1);
        return_from_interrupt_instr;
        $display("test disable nmi hold complete");
        // entries 3 and 7 are not blocking: other status load, bit test
        for (i = 0; i < 8; i++)
        begin
            cpu_model_inst.retire_one(kinds[i], i == 2 ? 5'h05 : (i == 3 ? 5'h03 : 5'h00));
            cpu_model_inst.fire(8'h10, 1'b0);
            if (i == 3 || i == 7)
                want_grant(3'h4, 3'h4, 4);
            else
            begin
                want_none(12);
                cpu_model_inst.retire_one(nip_pkg::INSTR_OTHER, 5'h00);
                want_grant(3'h4, 3'h4, 1);
            end
            return_from_interrupt_instr;
        end
        $display("test blocking complete");
        axi_write(8'h04, 32'h4, resp);
        axi_write(8'h18, 32'h4, resp);
        cpu_model_inst.fire(8'h42, 1'b0);
        want_grant(3'h1, 3'h4, 4);
        return_from_interrupt_instr;
        want_grant(3'h6, 3'h4, 1);
        return_from_interrupt_instr;
        axi_write(8'h04, 32'h1, resp);
        axi_write(8'h18, 32'h6, resp);
        $display("test tie complete");
        axi_write(8'h20, 32'h44, resp);
        axi_read(8'h20, rd, resp);
        chk(rd, 32'h44, "pin mode");
        cpu_model_inst.fire(8'h04, 1'b0);
        want_none(12);
        cpu_model_inst.fire(8'h04, 1'b1);
        want_grant(3'h2, 3'h2, 4);
        return_from_interrupt_instr;
        cpu_model_inst.fire(8'h40, 1'b1);
        want_grant(3'h6, 3'h6, 4);
        return_from_interrupt_instr;
        axi_write(8'h00, 32'h40, resp);
        cpu_model_inst.fire(8'h01, 1'b0);
        want_none(12);
        $display("test pins and mask complete");
        conclude;
    end
endmodule
